/* design/osc_defs.svh */
// offsets, field positions, reset values and timing counts of the oscillator control
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH
`define OSC_ADDR_CTL        12'hF86
`define OSC_ADDR_TRIM       12'hF87
`define OSC_ADDR_STAT       12'hF88
`define OSC_ADDR_MASK       12'hF89
`define OSC_BIT_RC_EN       7
`define OSC_BIT_RSVD        6
`define OSC_BIT_WDT_EN      5
`define OSC_BIT_PFD_EN      4
`define OSC_BIT_WFD_EN      3
`define OSC_CTL_RESET       8'hA0
`define OSC_UNLOCK_FIRST    8'hE7
`define OSC_UNLOCK_SECOND   8'h18
`define OSC_STAT_PRIMARY    0
`define OSC_STAT_WATCHDOG   1
`define OSC_WDT_FAIL_CYCLES 14'd8004
`define OSC_PRIMARY_WINDOW  14'd8191
`endif

/* design/osc_pkg.sv */
// types of the oscillator control block
package osc_pkg;
   typedef enum logic [1:0] {
      OSC_LOCKED  = 2'b00,
      OSC_HALF    = 2'b01,
      OSC_OPEN    = 2'b10
   } osc_lock_t;
   typedef enum logic [2:0] {
      OSC_SRC_RC_FAST = 3'b000,
      OSC_SRC_RC_SLOW = 3'b001,
      OSC_SRC_WDT     = 3'b011,
      OSC_SRC_EXT     = 3'b100
   } osc_src_t;
endpackage

/* design/osc_ctrl.sv */
// oscillator source control register, unlock sequencer, trim and clock failure detectors
`timescale 1ns/1ps
`include "osc_defs.svh"
module osc_ctrl
   import osc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [11:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [7:0]  rdata,
   input  wire logic [7:0]  option_trim,
   input  wire logic        primary_tick,
   input  wire logic        watchdog_tick,
   output logic             rc_osc_enable,
   output logic             watchdog_osc_enable,
   output logic             primary_fail_detect_enable,
   output logic             watchdog_osc_fail_detect_enable,
   output logic      [2:0]  system_clock_source_select,
   output logic      [7:0]  rc_trim,
   output logic             primary_fail_nmi,
   output logic             watchdog_fail_nmi,
   output logic             irq
);
   function automatic logic src_legal(input logic [2:0] code);
      return code == OSC_SRC_RC_FAST || code == OSC_SRC_RC_SLOW ||
             code == OSC_SRC_WDT || code == OSC_SRC_EXT;
   endfunction

   osc_lock_t   lock_q;
   logic [7:0]  ctl_q;
   logic [2:0]  src_q;
   logic [7:0]  trim_q;
   logic        trim_own_q;
   logic [1:0]  stat_q;
   logic [1:0]  mask_q;
   logic [13:0] pcnt_q;
   logic [13:0] wcnt_q;
   logic        pfail_q;
   logic        wfail_q;
   logic        wfail_dead_q;
   logic        wr_ctl;
   logic        data_wr;
   logic        pfail_ev;
   logic        wfail_ev;

   assign wr_ctl  = wr_en && addr == `OSC_ADDR_CTL;
   assign data_wr = wr_ctl && lock_q == OSC_OPEN;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_q <= OSC_LOCKED;
      end else if (wr_ctl) begin
         unique case (lock_q)
            OSC_LOCKED: lock_q <= (wdata == `OSC_UNLOCK_FIRST) ? OSC_HALF : OSC_LOCKED;
            OSC_HALF:   lock_q <= (wdata == `OSC_UNLOCK_SECOND) ? OSC_OPEN :
                                  (wdata == `OSC_UNLOCK_FIRST) ? OSC_HALF : OSC_LOCKED;
            OSC_OPEN:   lock_q <= OSC_LOCKED;
            default:    lock_q <= OSC_LOCKED;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_q <= `OSC_CTL_RESET;
      end else if (data_wr) begin
         ctl_q <= {wdata[7], 1'b0, wdata[5:0]};
      end
   end

   // running source: reserved codes keep it, primary failure forces watchdog
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         src_q <= OSC_SRC_RC_FAST;
      end else if (pfail_ev) begin
         src_q <= OSC_SRC_WDT;
      end else if (data_wr && src_legal(wdata[2:0])) begin
         src_q <= wdata[2:0];
      end
   end

   assign rc_osc_enable                   = ctl_q[`OSC_BIT_RC_EN];
   assign watchdog_osc_enable             = ctl_q[`OSC_BIT_WDT_EN];
   assign primary_fail_detect_enable      = ctl_q[`OSC_BIT_PFD_EN];
   assign watchdog_osc_fail_detect_enable = ctl_q[`OSC_BIT_WFD_EN];
   assign system_clock_source_select      = src_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trim_own_q <= 1'b0;
         trim_q     <= 8'h00;
      end else if (wr_en && addr == `OSC_ADDR_TRIM) begin
         trim_own_q <= 1'b1;
         trim_q     <= wdata;
      end
   end
   assign rc_trim = trim_own_q ? trim_q : option_trim;

   // primary detector: no primary tick within the window means loss if the watchdog oscillator is enabled, not yet failed and not the source
   assign pfail_ev = primary_fail_detect_enable && !wfail_dead_q && watchdog_osc_enable &&
                     src_q != OSC_SRC_WDT && !pfail_q && pcnt_q == `OSC_PRIMARY_WINDOW;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pcnt_q  <= 14'h0000;
         pfail_q <= 1'b0;
      end else if (!primary_fail_detect_enable || primary_tick) begin
         pcnt_q  <= 14'h0000;
         pfail_q <= 1'b0;
      end else if (pcnt_q != `OSC_PRIMARY_WINDOW) begin
         pcnt_q <= pcnt_q + 14'h0001;
      end else if (pfail_ev) begin
         pfail_q <= 1'b1;
      end
   end

   assign wfail_ev = watchdog_osc_fail_detect_enable && !wfail_q &&
                     wcnt_q == `OSC_WDT_FAIL_CYCLES - 14'd1 && !watchdog_tick;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wcnt_q       <= 14'h0000;
         wfail_q      <= 1'b0;
         wfail_dead_q <= 1'b0;
      end else if (!watchdog_osc_fail_detect_enable || watchdog_tick) begin
         wcnt_q  <= 14'h0000;
         wfail_q <= 1'b0;
      end else if (wfail_ev) begin
         wcnt_q       <= `OSC_WDT_FAIL_CYCLES;
         wfail_q      <= 1'b1;
         wfail_dead_q <= 1'b1;
      end else if (!wfail_q) begin
         wcnt_q <= wcnt_q + 14'h0001;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         primary_fail_nmi  <= 1'b0;
         watchdog_fail_nmi <= 1'b0;
      end else begin
         primary_fail_nmi  <= pfail_ev;
         watchdog_fail_nmi <= wfail_ev;
      end
   end

   // sticky status, set wins over write-one clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stat_q <= 2'b00;
      end else begin
         stat_q <= (stat_q & ~((wr_en && addr == `OSC_ADDR_STAT) ? wdata[1:0] : 2'b00))
                   | {wfail_ev, pfail_ev};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mask_q <= 2'b00;
      end else if (wr_en && addr == `OSC_ADDR_MASK) begin
         mask_q <= wdata[1:0];
      end
   end
   assign irq = |(stat_q & mask_q);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 8'h00;
      end else if (rd_en) begin
         unique case (addr)
            `OSC_ADDR_CTL:  rdata <= {ctl_q[7], 1'b0, ctl_q[5:3], src_q};
            `OSC_ADDR_TRIM: rdata <= rc_trim;
            `OSC_ADDR_STAT: rdata <= {6'h00, stat_q};
            `OSC_ADDR_MASK: rdata <= {6'h00, mask_q};
            default:        rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // shadow quiet counters kept apart from the detectors, read by the checkers only
   logic [13:0] wquiet_q;
   logic [13:0] pquiet_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wquiet_q <= 14'h0000;
      end else if (!watchdog_osc_fail_detect_enable || watchdog_tick) begin
         wquiet_q <= 14'h0000;
      end else if (wquiet_q != 14'h3FFF) begin
         wquiet_q <= wquiet_q + 14'h0001;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pquiet_q <= 14'h0000;
      end else if (!primary_fail_detect_enable || primary_tick) begin
         pquiet_q <= 14'h0000;
      end else if (pquiet_q != 14'h3FFF) begin
         pquiet_q <= pquiet_q + 14'h0001;
      end
   end

   chk_lock_after_write: assert property (@(posedge clk) disable iff (!reset_n)
      data_wr |=> lock_q == OSC_LOCKED)
      else $error("register not relocked");
   chk_unlock_order: assert property (@(posedge clk) disable iff (!reset_n)
      (lock_q == OSC_LOCKED && wr_ctl) |=> lock_q != OSC_OPEN)
      else $error("bad unlock");
   chk_unlock_second: assert property (@(posedge clk) disable iff (!reset_n)
      (lock_q == OSC_HALF && wr_ctl && wdata == `OSC_UNLOCK_SECOND) |=> lock_q == OSC_OPEN)
      else $error("unlock pair not taken");
   chk_locked_no_change: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_ctl && lock_q != OSC_OPEN) |=> $stable(ctl_q))
      else $error("locked write took");
   chk_half_keeps: assert property (@(posedge clk) disable iff (!reset_n)
      (lock_q == OSC_HALF && !wr_ctl) |=> lock_q == OSC_HALF)
      else $error("half unlock lost");
   chk_open_holds: assert property (@(posedge clk) disable iff (!reset_n)
      (lock_q == OSC_OPEN && !wr_ctl) |=> lock_q == OSC_OPEN)
      else $error("open state lost");
   chk_reserved_bit_zero: assert property (@(posedge clk) disable iff (!reset_n)
      ctl_q[`OSC_BIT_RSVD] == 1'b0)
      else $error("reserved bit set");
   chk_read_rsvd_zero: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_en && addr == `OSC_ADDR_CTL) |=> rdata[`OSC_BIT_RSVD] == 1'b0)
      else $error("reserved bit read as one");
   chk_ctl_write_bits: assert property (@(posedge clk) disable iff (!reset_n)
      data_wr |=> rc_osc_enable == $past(wdata[`OSC_BIT_RC_EN]) &&
                  watchdog_osc_enable == $past(wdata[`OSC_BIT_WDT_EN]) &&
                  primary_fail_detect_enable == $past(wdata[`OSC_BIT_PFD_EN]) &&
                  watchdog_osc_fail_detect_enable == $past(wdata[`OSC_BIT_WFD_EN]))
      else $error("control bits not taken");
   chk_src_legal: assert property (@(posedge clk) disable iff (!reset_n)
      src_legal(src_q))
      else $error("illegal source");
   chk_rsvd_keeps_src: assert property (@(posedge clk) disable iff (!reset_n)
      (data_wr && !src_legal(wdata[2:0]) && !pfail_ev) |=> $stable(src_q))
      else $error("reserved code changed source");
   chk_src_write: assert property (@(posedge clk) disable iff (!reset_n)
      (data_wr && src_legal(wdata[2:0]) && !pfail_ev) |=> src_q == $past(wdata[2:0]))
      else $error("source not taken");
   chk_reset_fields: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(reset_n) |-> system_clock_source_select == OSC_SRC_RC_FAST &&
                         !primary_fail_detect_enable && !watchdog_osc_fail_detect_enable)
      else $error("bad reset fields");
   chk_pfail_switch: assert property (@(posedge clk) disable iff (!reset_n)
      pfail_ev |=> src_q == OSC_SRC_WDT && primary_fail_nmi)
      else $error("no switchover");
   chk_pfail_needs_wdt: assert property (@(posedge clk) disable iff (!reset_n)
      pfail_ev |-> watchdog_osc_enable && src_q != OSC_SRC_WDT)
      else $error("switchover without watchdog");
   chk_pfail_window: assert property (@(posedge clk) disable iff (!reset_n)
      pfail_ev |-> pquiet_q >= `OSC_PRIMARY_WINDOW)
      else $error("primary failure too early");
   chk_pfail_status: assert property (@(posedge clk) disable iff (!reset_n)
      pfail_ev |=> stat_q[`OSC_STAT_PRIMARY])
      else $error("primary status not set");
   chk_pnmi_single: assert property (@(posedge clk) disable iff (!reset_n)
      primary_fail_nmi |=> !primary_fail_nmi)
      else $error("primary event too long");
   chk_wfail_count: assert property (@(posedge clk) disable iff (!reset_n)
      wfail_ev |-> wquiet_q == `OSC_WDT_FAIL_CYCLES - 14'd1)
      else $error("watchdog count wrong");
   chk_wfail_limit: assert property (@(posedge clk) disable iff (!reset_n)
      (watchdog_osc_fail_detect_enable && !watchdog_tick &&
       wquiet_q == `OSC_WDT_FAIL_CYCLES - 14'd1) |-> wfail_ev)
      else $error("watchdog failure missed");
   chk_wfail_no_switch: assert property (@(posedge clk) disable iff (!reset_n)
      (wfail_ev && !pfail_ev && !data_wr) |=> $stable(src_q))
      else $error("watchdog failure switched source");
   chk_wfail_status: assert property (@(posedge clk) disable iff (!reset_n)
      wfail_ev |=> stat_q[`OSC_STAT_WATCHDOG] && watchdog_fail_nmi)
      else $error("watchdog status not set");
   chk_wnmi_single: assert property (@(posedge clk) disable iff (!reset_n)
      watchdog_fail_nmi |=> !watchdog_fail_nmi)
      else $error("watchdog event too long");
   chk_trim_select: assert property (@(posedge clk) disable iff (!reset_n)
      !trim_own_q |-> rc_trim == option_trim)
      else $error("trim not from option");
   chk_trim_override: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_en && addr == `OSC_ADDR_TRIM) |=> rc_trim == $past(wdata))
      else $error("trim not overridden");
   chk_ctl_reset_en: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(reset_n) |-> rc_osc_enable && watchdog_osc_enable)
      else $error("bad reset");

   cov_unlock_write: cover property (@(posedge clk) disable iff (!reset_n) data_wr);
   cov_reserved_code: cover property (@(posedge clk) disable iff (!reset_n)
      data_wr && !src_legal(wdata[2:0]));
   cov_primary_fail: cover property (@(posedge clk) disable iff (!reset_n) pfail_ev);
   cov_watchdog_fail: cover property (@(posedge clk) disable iff (!reset_n) wfail_ev);
   cov_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
endmodule

/* verif/tb_osc_ctrl.sv */
// self-checking bench of the oscillator source control block
`timescale 1ns/1ps
`include "osc_defs.svh"
module tb_osc_ctrl;
   logic        clk;
   logic        reset_n;
   logic [11:0] addr;
   logic [7:0]  wdata;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  rdata;
   logic [7:0]  option_trim;
   logic        primary_tick  = 1'b0;
   logic        watchdog_tick = 1'b0;
   logic        p_run;
   logic        w_run;
   logic        rc_en, wdt_en, pfd_en, wfd_en, p_nmi, w_nmi, irq;
   logic [2:0]  sel;
   logic [7:0]  rc_trim;
   int          err_count, checks, n;
   logic [2:0]  codes [8] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h2, 3'h5, 3'h6, 3'h7};

   osc_ctrl osc_ctrl_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .option_trim(option_trim),
      .primary_tick(primary_tick), .watchdog_tick(watchdog_tick), .rc_osc_enable(rc_en),
      .watchdog_osc_enable(wdt_en), .primary_fail_detect_enable(pfd_en),
      .watchdog_osc_fail_detect_enable(wfd_en), .system_clock_source_select(sel),
      .rc_trim(rc_trim), .primary_fail_nmi(p_nmi), .watchdog_fail_nmi(w_nmi), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // oscillator edge pulses, stopped to provoke failures
   always @(posedge clk) begin
      primary_tick  <= p_run & ~primary_tick;
      watchdog_tick <= w_run & ~watchdog_tick;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a; rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rdata, exp, "read");
   endtask

   task automatic ctl(input logic [7:0] d);
      wr(`OSC_ADDR_CTL, `OSC_UNLOCK_FIRST);
      wr(`OSC_ADDR_CTL, `OSC_UNLOCK_SECOND);
      wr(`OSC_ADDR_CTL, d);
   endtask

   task automatic pins(input logic [7:0] exp);
      chk({rc_en, 1'b0, wdt_en, pfd_en, wfd_en, sel}, exp, "pins");
   endtask

   task automatic wait_nmi(input bit prim);
      n = 0;
      while (((prim ? p_nmi : w_nmi) !== 1'b1) && n < 9000) begin
         @(posedge clk);
         #1 n++;
      end
      chk({7'h0, prim ? p_nmi : w_nmi}, 8'h01, "nmi");
      chk({7'h0, n >= (prim ? 8192 : 8004)}, 8'h01, "nmi too early");
      chk({7'h0, n <= (prim ? 8193 : 8005)}, 8'h01, "nmi too late");
      @(posedge clk);
      #1 chk({7'h0, p_nmi | w_nmi}, 8'h00, "nmi width");
   endtask

   task automatic do_reset;
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      #1;
   endtask

   task automatic t_reset;
      do_reset;
      pins(8'hA0);
      rd(`OSC_ADDR_CTL, 8'hA0);
      chk(rc_trim, 8'h3C, "trim");
      rd(12'h000, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_lock;
      wr(`OSC_ADDR_CTL, 8'h13);
      wr(`OSC_ADDR_CTL, `OSC_UNLOCK_FIRST);
      wr(`OSC_ADDR_CTL, 8'h55);
      wr(`OSC_ADDR_CTL, `OSC_UNLOCK_SECOND);
      wr(`OSC_ADDR_CTL, 8'h13);
      rd(`OSC_ADDR_CTL, 8'hA0);
      wr(`OSC_ADDR_CTL, `OSC_UNLOCK_FIRST);
      wr(`OSC_ADDR_MASK, 8'h00);
      rd(`OSC_ADDR_STAT, 8'h00);
      wr(`OSC_ADDR_CTL, `OSC_UNLOCK_SECOND);
      wr(`OSC_ADDR_CTL, 8'hDC);
      pins(8'h9C);
      rd(`OSC_ADDR_CTL, 8'h9C);
      wr(`OSC_ADDR_CTL, 8'h20);
      rd(`OSC_ADDR_CTL, 8'h9C);
      $display("test lock done");
   endtask

   task automatic t_codes;
      foreach (codes[i]) begin
         ctl({5'b10100, codes[i]});
         pins(i < 4 ? {5'b10100, codes[i]} : 8'hA4);
      end
      ctl(8'h00);
      pins(8'h00);
      wr(`OSC_ADDR_TRIM, 8'h5A);
      chk(rc_trim, 8'h5A, "trim");
      $display("test codes done");
   endtask

   task automatic t_wdfail;
      ctl(8'hA8);
      w_run <= 1'b0;
      wait_nmi(1'b0);
      pins(8'hA8);
      rd(`OSC_ADDR_STAT, 8'h02);
      chk({7'h0, irq}, 8'h00, "irq masked");
      wr(`OSC_ADDR_MASK, 8'h02);
      chk({7'h0, irq}, 8'h01, "irq");
      wr(`OSC_ADDR_STAT, 8'h02);
      chk({7'h0, irq}, 8'h00, "irq clear");
      w_run <= 1'b1;
      $display("test watchdog failure done");
   endtask

   task automatic t_pfail;
      do_reset;
      ctl(8'hB0);
      p_run <= 1'b0;
      wait_nmi(1'b1);
      pins(8'hB3);
      rd(`OSC_ADDR_STAT, 8'h01);
      chk(rc_trim, 8'h3C, "trim after reset");
      p_run <= 1'b1;
      $display("test primary failure done");
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #200000;
      err_count++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      complete_run;
   end

   initial begin
      reset_n = 1'b0; addr = 12'h000; wdata = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
      option_trim = 8'h3C; p_run = 1'b1; w_run = 1'b1;
      t_reset;
      t_lock;
      t_codes;
      t_wdfail;
      t_pfail;
      complete_run;
   end
endmodule
